// ==== tlm_readout.sv ====
// telemetry readout: current, power and temperature words served as byte pairs
// assumes converter codes arrive synchronous to clk and one byte read port
// from the serial management bus front end, one request per pulse
`timescale 1ns/1ps
`default_nettype none
`include "tlm_defs.svh"

module tlm_readout (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`TLM_CODE_W-1:0] load_current_sense_input,
   input wire logic [`TLM_CODE_W-1:0] remote_voltage_sense_input,
   input wire logic [`TLM_CODE_W-1:0] temperature_sense_input,
   input wire logic [1:0] nominal_range,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_valid
);
   import tlm_pkg::*;

   logic [`TLM_CODE_W-1:0] cur_ff, nxt_cur;
   logic [`TLM_WORD_W-1:0] pwr_ff, nxt_pwr;
   logic [`TLM_CODE_W-1:0] tmp_ff, nxt_tmp;
   logic [`TLM_PROD_W-1:0] prod;
   logic [`TLM_WORD_W-1:0] snap_ff, nxt_snap;
   logic [`TLM_WORD_W-1:0] word;
   logic [7:0] last_addr_ff, nxt_last_addr;
   logic [7:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff, nxt_rd_valid;
   tlm_phase_t phase_ff, nxt_phase;
   logic mapped;
   logic first_rd;

   // measurement words, refreshed every cycle
   always_comb begin
      nxt_cur = load_current_sense_input;
      case (nominal_range)
         `TLM_RNG_MID: begin
            // half step size: double the code, clip at full scale
            if (load_current_sense_input >= `TLM_HALF_SCALE) begin
               nxt_cur = `TLM_CODE_MAX;
            end else begin
               nxt_cur = {load_current_sense_input[`TLM_CODE_W-2:0], 1'b0};
            end
         end
         `TLM_RNG_LOW: begin
            // quarter step size: a quarter of full scale or more saturates
            if (load_current_sense_input >= `TLM_QUARTER_SCALE) begin
               nxt_cur = `TLM_CODE_MAX;
            end else begin
               nxt_cur = {load_current_sense_input[`TLM_CODE_W-3:0], 2'b00};
            end
         end
         default: begin
            nxt_cur = load_current_sense_input;
         end
      endcase
      // product keeps its top 16 bits; low bits are below the power lsb
      prod = remote_voltage_sense_input * cur_ff;
      nxt_pwr = prod[`TLM_PROD_W-1:`TLM_PWR_LSB];
      nxt_tmp = temperature_sense_input;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur_ff <= 12'h000;
         pwr_ff <= 16'h0000;
         tmp_ff <= 12'h000;
      end else begin
         cur_ff <= nxt_cur;
         pwr_ff <= nxt_pwr;
         tmp_ff <= nxt_tmp;
      end
   end

   // byte-pair read port
   always_comb begin
      mapped = 1'b1;
      case (rd_addr)
         `TLM_OFS_CURRENT: word = {cur_ff, `TLM_RSVD_NIBBLE};
         `TLM_OFS_POWER: word = pwr_ff;
         `TLM_OFS_TEMP: word = {tmp_ff, `TLM_RSVD_NIBBLE};
         default: begin
            word = 16'h0000;
            mapped = 1'b0;
         end
      endcase
      // a read of another register restarts the pair
      first_rd = (phase_ff == TLM_HI) || (rd_addr != last_addr_ff);
      nxt_snap = snap_ff;
      nxt_phase = phase_ff;
      nxt_last_addr = last_addr_ff;
      nxt_rd_data = rd_data_ff;
      nxt_rd_valid = rd_req;
      if (rd_req) begin
         if (!mapped) begin
            nxt_rd_data = `TLM_UNMAPPED_BYTE;
            nxt_phase = TLM_HI;
         end else if (first_rd) begin
            nxt_snap = word;
            nxt_rd_data = word[15:8];
            nxt_phase = TLM_LO;
            nxt_last_addr = rd_addr;
         end else begin
            // both halves come from one sample
            nxt_rd_data = snap_ff[7:0];
            nxt_phase = TLM_HI;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         snap_ff <= 16'h0000;
         phase_ff <= TLM_HI;
         last_addr_ff <= 8'h00;
         rd_data_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         snap_ff <= nxt_snap;
         phase_ff <= nxt_phase;
         last_addr_ff <= nxt_last_addr;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;

   // checks skip the edge that releases reset: the flops are still clear
   // there while $past already sees live inputs, hence the !sys_rst terms
   a_cur_low_nibble: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_req && rd_addr == `TLM_OFS_CURRENT && !first_rd) |=> rd_data[3:0] == 4'h0)
      else $error("current low nibble not zero");
   a_temp_low_nibble: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_req && rd_addr == `TLM_OFS_TEMP && !first_rd) |=> rd_data[3:0] == 4'h0)
      else $error("temperature low nibble not zero");

   // range scaling, one check per range code, plus one clip check shared by the mid and low codes
   a_scale_wide: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && nominal_range == `TLM_RNG_HIGH)
      |=> cur_ff == $past(load_current_sense_input))
      else $error("wide range current not passed through");
   a_scale_alt: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && nominal_range == `TLM_RNG_HIGH_ALT)
      |=> cur_ff == $past(load_current_sense_input))
      else $error("spare wide range code not passed through");
   a_scale_mid: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && nominal_range == `TLM_RNG_MID && load_current_sense_input < `TLM_HALF_SCALE)
      |=> cur_ff == {$past(load_current_sense_input[10:0]), 1'b0})
      else $error("mid range current not doubled");
   a_scale_low: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && nominal_range == `TLM_RNG_LOW
         && load_current_sense_input < `TLM_QUARTER_SCALE)
      |=> cur_ff == {$past(load_current_sense_input[9:0]), 2'b00})
      else $error("low range current not quadrupled");
   a_scale_clip: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst
         && ((nominal_range == `TLM_RNG_MID && load_current_sense_input >= `TLM_HALF_SCALE)
         || (nominal_range == `TLM_RNG_LOW && load_current_sense_input >= `TLM_QUARTER_SCALE)))
      |=> cur_ff == `TLM_CODE_MAX)
      else $error("scaled current not clipped at full scale");

   // independent 24-bit product, so a narrowed multiplier shows up here
   a_power_prod: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst |=> pwr_ff == 16'(({12'h000, $past(remote_voltage_sense_input)}
         * {12'h000, $past(cur_ff)}) >> `TLM_PWR_LSB))
      else $error("power word not product of codes");
   a_temp_pass: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst |=> tmp_ff == $past(temperature_sense_input))
      else $error("temperature code altered");

   // byte-pair sequencing
   a_first_msb: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && rd_req && mapped && first_rd)
      |=> rd_valid && rd_data == $past(word[15:8]) && phase_ff == TLM_LO)
      else $error("first read did not return high byte");
   a_first_snap: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && rd_req && mapped && first_rd)
      |=> snap_ff == $past(word) && last_addr_ff == $past(rd_addr))
      else $error("first read did not capture the whole word");
   a_second_lsb: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && rd_req && mapped && !first_rd)
      |=> rd_data == $past(snap_ff[7:0]) && phase_ff == TLM_HI)
      else $error("second read not from snapshot");
   a_snap_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && phase_ff == TLM_LO && !rd_req) |=> $stable(snap_ff) && phase_ff == TLM_LO)
      else $error("snapshot changed between reads");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && rd_req && !mapped)
      |=> rd_valid && rd_data == `TLM_UNMAPPED_BYTE && phase_ff == TLM_HI)
      else $error("unmapped read not answered with zero");

   // answer strobe and data holding
   a_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && rd_req) |=> rd_valid ##1 (rd_valid == $past(rd_req)))
      else $error("read answer not one cycle after request");
   a_valid_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && !rd_req) |=> !rd_valid)
      else $error("answer strobe without request");
   a_data_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && !rd_req) |=> $stable(rd_data))
      else $error("read data moved without request");
   // no disable here: this one watches reset itself
   a_reset_quiet: assert property (@(posedge clk)
      sys_rst |=> !rd_valid && rd_data == 8'h00 && phase_ff == TLM_HI)
      else $error("reset did not clear the read port");

endmodule // tlm_readout

`default_nettype wire

// ==== tlm_defs.svh ====
// telemetry readout constants: offsets, field positions, range codes
// assumes inclusion by bare name from the top module
`ifndef TLM_DEFS_SVH
`define TLM_DEFS_SVH

`define TLM_OFS_CURRENT 8'h18
`define TLM_OFS_POWER 8'h19
`define TLM_OFS_TEMP 8'h1A
`define TLM_UNMAPPED_BYTE 8'h00
`define TLM_CODE_W 12
`define TLM_WORD_W 16
`define TLM_PROD_W 24
`define TLM_PWR_LSB 8
`define TLM_RSVD_NIBBLE 4'h0
`define TLM_CODE_MAX 12'hFFF
`define TLM_RNG_LOW 2'h0
`define TLM_RNG_MID 2'h1
`define TLM_RNG_HIGH 2'h2
`define TLM_RNG_HIGH_ALT 2'h3
`define TLM_HALF_SCALE 12'h800
`define TLM_QUARTER_SCALE 12'h400

`endif

// ==== tlm_pkg.sv ====
// telemetry readout types: byte-pair read phase
// assumes tlm_defs.svh on the include path
package tlm_pkg;
   typedef enum logic [1:0] {
      TLM_HI = 2'b01,
      TLM_LO = 2'b10
   } tlm_phase_t;
endpackage

// ==== tlm_host.sv ====
// host model: serial management byte reads, issued as pairs with an optional idle gap between the bytes
// assumes the readout answers one cycle after each taken request
`timescale 1ns/1ps
`default_nettype none
module tlm_host (
   input wire logic clk,
   output logic rd_req,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial begin
      rd_req = 1'b0;
      rd_addr = 8'h00;
   end
   // res[17:16] carry the two valid strobes, res[15:0] the assembled word;
   // gap idles the strobe for that many cycles between the two bytes
   task automatic read_pair(input logic [7:0] addr, input int gap, output logic [17:0] res);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_addr <= addr;
      @(posedge clk);
      if (gap > 0) begin
         rd_req <= 1'b0;
      end
      #1 res[17] = rd_valid;
      res[15:8] = rd_data;
      if (gap > 0) begin
         repeat (gap) @(posedge clk);
         rd_req <= 1'b1;
      end
      @(posedge clk);
      rd_req <= 1'b0;
      #1 res[16] = rd_valid;
      // low byte of the addressed word; turning it into units is the caller's job
      res[7:0] = rd_data;
   endtask
endmodule // tlm_host
`default_nettype wire

// ==== testbench.sv ====
// testbench: random codes, ranges stepped in turn, every word read as a byte pair
// assumes tlm_readout and tlm_host compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] cur = 12'h000;
   logic [11:0] volt = 12'h000;
   logic [11:0] temp = 12'h000;
   logic [1:0] rng = 2'h0;
   logic rd_req, rd_valid;
   logic [7:0] rd_addr, rd_data;
   logic [17:0] res;
   logic [23:0] prod;
   logic [31:0] lfsr = 32'hFC98;
   int n_mismatch = 0;
   int comparisons = 0;
   always #50 clk = ~clk;
   tlm_readout tlm_readout_inst (.clk(clk), .sys_rst(sys_rst),
      .load_current_sense_input(cur), .remote_voltage_sense_input(volt),
      .temperature_sense_input(temp), .nominal_range(rng), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
   tlm_host tlm_host_inst (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid));
   function automatic logic [11:0] scaled(input logic [11:0] c, input logic [1:0] r);
      logic [13:0] w;
      w = (r == 2'h0) ? {c, 2'h0} : (r == 2'h1) ? {1'b0, c, 1'b0} : {2'h0, c};
      return (w > 14'h0FFF) ? 12'hFFF : w[11:0];
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check_idle();
      comparisons++;
      if (rd_valid !== 1'b0 || rd_data !== 8'h00) begin
         n_mismatch++;
         $display("CHECK FAILED %0t reset left data %h valid %b", $time, rd_data, rd_valid);
      end
   endtask
   task automatic check16(input logic [17:0] got, input logic [15:0] want);
      comparisons++;
      if (got !== {2'h3, want}) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, want);
      end
   endtask
   // inputs flip as the request goes up, so the low byte must come from the snapshot
   task automatic read_word(input logic [7:0] a, input int gap, input logic [15:0] want);
      fork
         tlm_host_inst.read_pair(a, gap, res);
         begin
            @(posedge clk);
            cur <= ~cur;
            volt <= ~volt;
            temp <= ~temp;
         end
      join
      check16(res, want);
      @(posedge clk);
      cur <= ~cur;
      volt <= ~volt;
      temp <= ~temp;
      repeat (4) @(posedge clk);
   endtask
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         lfsr = lfsr_next(lfsr);
         cur <= (i < 2) ? {12{i[0]}} : lfsr[11:0];
         volt <= (i < 2) ? {12{i[0]}} : lfsr[23:12];
         temp <= (i == 1) ? 12'hF7C : lfsr[27:16];
         rng <= i[1:0];
         sys_rst <= (i == 20);
         repeat (4) @(posedge clk);
         if (i == 20) begin
            // mid-run reset: the read port must come back quiet
            sys_rst <= 1'b0;
            #1 check_idle();
         end
         prod = volt * scaled(cur, rng);
         read_word(8'h1B, 0, 16'h0000);
         read_word(8'h18, lfsr[29:28], {scaled(cur, rng), 4'h0});
         read_word(8'h19, lfsr[30:29], prod[23:8]);
         read_word(8'h1A, lfsr[31:30], {temp, 4'h0});
      end
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule // testbench
`default_nettype wire
